// ### design/pfs_fault_signaling.v
/*
 * pcs receive fault signalling: forces local fault ordered sets onto the
 * 64-bit receive xgmii toward the mac while the receiver is not up, keeps
 * immediate and latching local fault / link status, and exposes them over
 * an axi4-lite slave with a sticky, maskable interrupt.
 * assumes every receive status input is on ref_clk except signal_detect and
 * the transceiver lock, which are pins and are synchronised here.
 * assumes the mac keys fault handling on lane 0 and makes remote fault itself.
 */
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`include "pfs_defs.vh"

// register map, one 32-bit word each on a 4-bit byte address:
//   0x0 ctrl      write-only pulses: clear lf latch, restore link latch, pcs reset
//   0x4 status    read-only copy of status_vec; a read clears both latches
//   0x8 irq_stat  sticky events: lf rising, link drop, buffer error; write one clears
//   0xC irq_mask  read/write, reset zero; irq is any unmasked sticky bit
//   other offsets answer slverr and read as zero
// ctrl pulses last one cycle and read back as zero; only byte lane 0 strobe is used,
// so writes that touch lanes 1 to 3 alone are silently ignored

module pfs_fault_signaling (
    input  wire        ref_clk,
    input  wire        rst_n,
    // receive path status
    input  wire        signal_detect,
    input  wire        xcvr_locked,
    input  wire        rx_reset,
    input  wire        block_lock,
    input  wire        high_error_rate_flag,
    input  wire        ebuf_overflow,
    input  wire        ebuf_underflow,
    input  wire        pma_pcs_reset,
    input  wire [1:0]  cfg_clear,
    // decoded receive data
    input  wire [63:0] dec_rxd,
    input  wire [7:0]  dec_rxc,
    // xgmii toward the mac
    output reg  [63:0] xgmii_rxd,
    output reg  [7:0]  xgmii_rxc,
    // status vector
    output wire [6:0]  status_vec,
    // interrupt
    output wire        irq,
    // axi4-lite slave
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // sync states
    localparam SYNC_LOSS = 1'b0;
    localparam SYNC_OK   = 1'b1;

    // pin synchroniser stages
    reg  [1:0]  sd_sync_q;
    reg  [1:0]  lk_sync_q;
    // receive state and latches
    reg         sync_state_q;
    reg         lf_latch_q;
    reg         ls_latch_q;
    reg         ls_now_q;
    reg         ufl_err_q;
    // register file
    reg  [2:0]  ctrl_q;
    reg  [`PFS_IRQ_W-1:0] irq_stat_q;
    reg  [`PFS_IRQ_W-1:0] irq_mask_q;
    reg         lf_prev_q;
    // write channel capture
    reg         aw_got_q;
    reg         w_got_q;
    reg  [3:0]  aw_addr_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;

    wire        sd_s = sd_sync_q[1];
    wire        lk_s = lk_sync_q[1];
    wire        any_reset = pma_pcs_reset | ctrl_q[`PFS_CTRL_PCS_RST];
    wire        ebuf_err = ebuf_overflow | ebuf_underflow;
    wire        lf_now;
    wire        wr_fire;
    wire        rd_fire;
    wire        st_read;
    wire        lf_clr;
    wire        ls_clr;
    wire [`PFS_IRQ_W-1:0] irq_ev;
    wire [`PFS_IRQ_W-1:0] irq_w1c;
    wire [63:0] lf_word;
    wire [63:0] err_word;

    // two-flop synchronisers for the pin level inputs
    // only the second stage is read, so a metastable first stage stays inside
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sd_sync_q <= 2'h0;
            lk_sync_q <= 2'h0;
        end else begin
            sd_sync_q <= {sd_sync_q[0], signal_detect};
            lk_sync_q <= {lk_sync_q[0], xcvr_locked};
        end
    end

    // sync machine pinned to loss of sync while signal detect is low
    // two states only: light plus block lock is enough to leave loss of sync
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_state_q <= SYNC_LOSS;
        end else begin
            case (sync_state_q)
                SYNC_LOSS: if (sd_s && block_lock) sync_state_q <= SYNC_OK;
                SYNC_OK:   if (!sd_s || !block_lock) sync_state_q <= SYNC_LOSS;
                default:   sync_state_q <= SYNC_LOSS;
            endcase
        end
    end

    // every not-up condition feeds one immediate fault term
    // pcs reset counts as well: the receive side is not up while it is held
    assign lf_now = !lk_s | rx_reset | (sync_state_q == SYNC_LOSS) |
                    high_error_rate_flag | ebuf_err | any_reset;

    // local fault set: 9C control in lane 0, fault code 01 in lane 3
    // upper column left zero; the mac keys fault handling on lane 0 alone
    assign lf_word  = {32'h0000_0000, `PFS_LF_BYTE2, 16'h0000, `PFS_SEQ_CHAR};
    assign err_word = {8{`PFS_ERR_CHAR}};

    // output mux; error block only on the first underflow cycle
    // the error block wins for one cycle, after that the fault set holds
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            xgmii_rxd <= {32'h0000_0000, `PFS_LF_BYTE2, 16'h0000, `PFS_SEQ_CHAR};
            xgmii_rxc <= 8'h11;
            ufl_err_q <= 1'b0;
        end else begin
            ufl_err_q <= ebuf_underflow;
            if (ebuf_underflow && !ufl_err_q) begin
                xgmii_rxd <= err_word;
                xgmii_rxc <= 8'hFF;
            end else if (lf_now) begin
                xgmii_rxd <= lf_word;
                xgmii_rxc <= 8'h11;
            end else begin
                // decoded traffic passes untouched; no remote fault made here
                xgmii_rxd <= dec_rxd;
                xgmii_rxc <= dec_rxc;
            end
        end
    end

    // a status read doubles as a latch clear on the accepting edge
    assign st_read = rd_fire && (s_axi_araddr == `PFS_REG_STATUS);

    // three clear sources plus reset for each latch
    assign lf_clr = cfg_clear[0] | ctrl_q[`PFS_CTRL_CLR_LF] | st_read | any_reset;
    assign ls_clr = cfg_clear[1] | ctrl_q[`PFS_CTRL_CLR_LS] | st_read | any_reset;

    // latching bits; a live fault wins over a clear in the same cycle
    // a reset raises lf_now for its whole length, so it leaves the fault latched
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lf_latch_q <= 1'b1;
            ls_latch_q <= 1'b0;
            ls_now_q   <= 1'b0;
            lf_prev_q  <= 1'b1;
        end else begin
            ls_now_q  <= !lf_now;
            lf_prev_q <= lf_now;
            if (lf_now)
                lf_latch_q <= 1'b1;
            else if (lf_clr)
                lf_latch_q <= 1'b0;
            if (lf_now)
                ls_latch_q <= 1'b0;
            else if (ls_clr)
                ls_latch_q <= 1'b1;
        end
    end

    assign status_vec = {ebuf_err, high_error_rate_flag, block_lock,
                         ls_latch_q, ls_now_q, lf_latch_q, lf_now};

    // interrupt events, sticky with set winning over write-one-clear
    // link drop uses the registered link bit, so a fault already present at
    // reset release is not counted as a drop
    assign irq_ev = {ebuf_err, ls_now_q & lf_now, lf_now & !lf_prev_q};
    assign irq_w1c = (wr_fire && aw_addr_q == `PFS_REG_IRQ_STAT && w_strb_q[0]) ?
                     w_data_q[`PFS_IRQ_W-1:0] : {`PFS_IRQ_W{1'b0}};
    assign irq = |(irq_stat_q & irq_mask_q);

    // sticky status register
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            irq_stat_q <= {`PFS_IRQ_W{1'b0}};
        else
            irq_stat_q <= (irq_stat_q & ~irq_w1c) | irq_ev;
    end

    // write channel: address and data caught in either order
    // a pending response blocks new addresses: one write under way at a time
    assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
    assign wr_fire = aw_got_q && w_got_q;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            aw_addr_q    <= 4'h0;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PFS_RESP_OKAY;
            ctrl_q       <= 3'h0;
            irq_mask_q   <= {`PFS_IRQ_W{1'b0}};
        end else begin
            // control clear bits are self-clearing one-cycle pulses
            ctrl_q <= 3'h0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q  <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q  <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `PFS_RESP_OKAY;
                case (aw_addr_q)
                    `PFS_REG_CTRL:
                        if (w_strb_q[0]) ctrl_q <= w_data_q[2:0];
                    `PFS_REG_IRQ_MASK:
                        if (w_strb_q[0]) irq_mask_q <= w_data_q[`PFS_IRQ_W-1:0];
                    `PFS_REG_STATUS, `PFS_REG_IRQ_STAT: ;
                    default: s_axi_bresp <= `PFS_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: one read at a time, answered the next cycle
    // status is sampled on the accepting edge, the same edge its clear lands
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `PFS_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `PFS_RESP_OKAY;
            case (s_axi_araddr)
                `PFS_REG_CTRL:     s_axi_rdata <= 32'h0000_0000;
                `PFS_REG_STATUS:   s_axi_rdata <= {25'h0, status_vec};
                `PFS_REG_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat_q};
                `PFS_REG_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `PFS_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // pfs_fault_signaling

// ### design/pfs_defs.vh
/*
 * constants for the pcs fault signalling block: xgmii control codes,
 * register offsets, field positions and axi response codes.
 * assumes inclusion by bare name from the design file only.
 */
`ifndef PFS_DEFS_VH
`define PFS_DEFS_VH

// xgmii code points
`define PFS_SEQ_CHAR      8'h9C
`define PFS_IDLE_CHAR     8'h07
`define PFS_ERR_CHAR      8'hFE
`define PFS_LF_BYTE2      8'h01
`define PFS_SEQ_LANE      0

// register byte offsets
`define PFS_REG_CTRL      4'h0
`define PFS_REG_STATUS    4'h4
`define PFS_REG_IRQ_STAT  4'h8
`define PFS_REG_IRQ_MASK  4'hC

// ctrl fields
`define PFS_CTRL_CLR_LF   0
`define PFS_CTRL_CLR_LS   1
`define PFS_CTRL_PCS_RST  2

// status fields
`define PFS_ST_LF_NOW     0
`define PFS_ST_LF_LATCH   1
`define PFS_ST_LS_NOW     2
`define PFS_ST_LS_LATCH   3
`define PFS_ST_BLK_LOCK   4
`define PFS_ST_HI_BER     5
`define PFS_ST_EBUF_ERR   6

// irq fields
`define PFS_IRQ_LF_RISE   0
`define PFS_IRQ_LINK_DOWN 1
`define PFS_IRQ_EBUF      2
`define PFS_IRQ_W         3

// axi response codes
`define PFS_RESP_OKAY     2'h0
`define PFS_RESP_SLVERR   2'h2

`endif

// ### verif/pfs_fault_signaling_props.sv
/*
 * checker for the pcs fault signalling block: fault ordered sets, latches.
 * assumes binding to the design top; status inputs held for several cycles.
 */
module pfs_fs_props (
    input logic        ref_clk,
    input logic        rst_n,
    input logic        signal_detect,
    input logic        block_lock,
    input logic        high_error_rate_flag,
    input logic        ebuf_underflow,
    input logic        pma_pcs_reset,
    input logic [1:0]  cfg_clear,
    input logic [63:0] dec_rxd,
    input logic [63:0] xgmii_rxd,
    input logic [7:0]  xgmii_rxc,
    input logic [6:0]  status_vec
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // underflow cycles excluded, they start with an error block
    property p_lf_set;
        status_vec[0] && !ebuf_underflow |=> xgmii_rxc == 8'h11
            && xgmii_rxd == 64'h0000_0000_0100_009C;
    endproperty
    a_lf_set: assert property (p_lf_set) else $error("no fault set");
    property p_pass;
        !status_vec[0] |=> xgmii_rxd == $past(dec_rxd);
    endproperty
    a_pass: assert property (p_pass) else $error("data not passed");
    property p_uf;
        $rose(ebuf_underflow) |=> xgmii_rxc == 8'hFF;
    endproperty
    a_uf: assert property (p_uf) else $error("no error block");
    // pin passes a two-flop synchroniser first
    property p_sd;
        !signal_detect [*4] |-> status_vec[0];
    endproperty
    a_sd: assert property (p_sd) else $error("sync left loss");
    property p_hb;
        high_error_rate_flag |-> ##[0:1] status_vec[0];
    endproperty
    a_hb: assert property (p_hb) else $error("ber no fault");
    property p_bl;
        !block_lock |-> ##[0:1] status_vec[0];
    endproperty
    a_bl: assert property (p_bl) else $error("lock no fault");
    property p_lat;
        status_vec[0] |=> status_vec[1] && !status_vec[3];
    endproperty
    a_lat: assert property (p_lat) else $error("latch wrong");
    property p_clr;
        cfg_clear[0] && !status_vec[0] |=> !status_vec[1] || status_vec[0];
    endproperty
    a_clr: assert property (p_clr) else $error("latch not cleared");
    property p_rst;
        pma_pcs_reset |-> ##[0:1] status_vec[0];
    endproperty
    a_rst: assert property (p_rst) else $error("reset no fault");
endmodule // pfs_fs_props

bind pfs_fault_signaling pfs_fs_props u_pfs_fs_props (.ref_clk, .rst_n, .signal_detect,
    .block_lock, .high_error_rate_flag, .ebuf_underflow, .pma_pcs_reset, .cfg_clear,
    .dec_rxd, .xgmii_rxd, .xgmii_rxc, .status_vec);

// ### verif/pfs_mac_rs_model.sv
/*
 * reconciliation layer stand-in on the far side of the receive xgmii.
 * assumes lane 0 carries the ordered set marker; tx is {txc, txd}.
 */
module pfs_mac_rs_model (
    input  logic        ref_clk,
    input  logic        rst_n,
    input  logic        rf_off,
    input  logic [63:0] rxd,
    input  logic [7:0]  rxc,
    output logic [71:0] tx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic is_seq;
    assign is_seq = rxc[0] && rxd[7:0] == 8'h9C;
    // pending data dropped outright, never queued behind a fault
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx <= {8'hFF, {8{8'h07}}};
        end else if (is_seq && rxd[31:24] == 8'h01 && !rf_off) begin
            tx <= {8'h11, 64'h0000_0000_0200_009C};
        end else if (is_seq) begin
            tx <= {8'hFF, {8{8'h07}}};
        end else begin
            tx <= {~rxc, ~rxd}; // stand-in for user frames
        end
    end
endmodule // pfs_mac_rs_model

// ### verif/pfs_fault_signaling_tb_top.sv
/*
 * testbench: fault conditions, latch clearing, interrupt, axi4-lite access.
 * assumes the design answers reads one cycle and writes two cycles after acceptance.
 */
module pfs_fault_signaling_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, rf_off = 1'b0;
    logic [7:0]  bad = 8'h00, dec_rxc = 8'h00;
    logic [1:0]  cfg_clear = 2'h0;
    logic [63:0] dec_rxd = 64'h0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    wire         awready, wready, bvalid, arready, rvalid, irq;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [63:0] xgmii_rxd;
    wire  [7:0]  xgmii_rxc;
    wire  [71:0] rs_tx;
    // control flag of lane 0 and the low column of what the mac sends back
    wire  [33:0] rs_tx_lo = {1'b0, rs_tx[64], rs_tx[31:0]};
    wire  [6:0]  status_vec;
    int          seed = 37158, n_fail = 0, samples_checked = 0, cyc = 0;
    logic [33:0] q[$];
    always #5 ref_clk = ~ref_clk;
    // bad bit n breaks one receive condition
    pfs_fault_signaling u_pfs_fault_signaling (.ref_clk, .rst_n, .signal_detect(~bad[0]),
        .xcvr_locked(~bad[1]), .rx_reset(bad[2]), .block_lock(~bad[3]),
        .high_error_rate_flag(bad[4]), .ebuf_overflow(bad[5]), .ebuf_underflow(bad[6]),
        .pma_pcs_reset(bad[7]), .cfg_clear, .dec_rxd, .dec_rxc, .xgmii_rxd, .xgmii_rxc,
        .status_vec, .irq, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    pfs_mac_rs_model u_pfs_mac_rs_model (.ref_clk, .rst_n, .rf_off(rf_off),
        .rxd(xgmii_rxd), .rxc(xgmii_rxc), .tx(rs_tx));
    task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        q.push_back(34'h0);
        @(posedge ref_clk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rdx(input logic [3:0] a, input logic [33:0] e);
        q.push_back(e);
        @(posedge ref_clk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask
    // results are matched in order, one transfer in flight at a time
    always @(posedge ref_clk) begin
        dec_rxd <= {$random(seed), $random(seed)};
        dec_rxc <= 8'($random(seed));
        if (bvalid && bready) chk("bresp", {bresp, 32'h0}, q.pop_front());
        if (rvalid && rready) chk("rdata", {rresp, rdata}, q.pop_front());
        if (++cyc == 5000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rdx(4'h4, 34'h16);
        rdx(4'h4, 34'h1C);
        $display("startup done");
        for (int i = 0; i < 8; i++) begin
            bad <= 8'h01 << i;
            rf_off <= (i == 1);
            repeat (6) @(posedge ref_clk);
            rdx(4'h4, {27'h0, i == 5 || i == 6, i == 4, i != 3, 4'h3});
            // the mac answers the fault set with remote fault, or idles when suppressed
            chk("rs_tx", rs_tx_lo, i == 1 ? 34'h1_0707_0707 : 34'h1_0200_009C);
            bad <= 8'h00;
            repeat (6) @(posedge ref_clk);
            // three ways to clear the latches
            if (i % 2 == 1) cfg_clear <= 2'h3;
            else if (i == 2) wr(4'h0, 32'h3);
            else rdx(4'h4, 34'h16);
            @(posedge ref_clk);
            cfg_clear <= 2'h0;
            rdx(4'h4, 34'h1C);
            $display("fault test %0d done", i);
        end
        #1 chk("irq", irq, 1'b0);
        wr(4'hC, 32'h7);
        @(posedge ref_clk);
        #1 chk("irq", irq, 1'b1);
        rdx(4'hC, 34'h7);
        // fault rise, link drop and buffer error were all seen in the loop
        rdx(4'h8, 34'h7);
        wr(4'h8, 32'h7);
        @(posedge ref_clk);
        #1 chk("irq", irq, 1'b0);
        rdx(4'h8, 34'h0);
        rdx(4'h2, 34'h2_0000_0000);
        // pcs reset pulse from ctrl raises fault for one cycle and latches it
        wr(4'h0, 32'h4);
        rdx(4'h4, 34'h16);
        $display("irq and bus done");
        close_out();
    end
endmodule // pfs_fault_signaling_tb_top
